// *** design/fmg_gateway.sv ***
// Field-bus master poller and serial slave channel settings, AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module fmg_gateway
  import fmg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic [1:0]  mode_select_switch_i,
  input  wire logic        hart_done_i,
  input  wire logic        hart_ok_i,
  input  wire logic [7:0]  hart_rc_i,
  input  wire logic [7:0]  hart_ds_i,
  input  wire logic        hart_rx_valid_i,
  input  wire logic [7:0]  hart_rx_idx_i,
  input  wire logic [7:0]  hart_rx_byte_i,
  input  wire logic [7:0]  hart_tx_idx_i,
  output logic             hart_req_o,
  output logic      [7:0]  hart_cmd_o,
  output logic      [3:0]  hart_slave_o,
  output logic      [7:0]  hart_tx_byte_o,
  output logic             hart_primary_o,
  output logic             mb_ascii_o,
  output logic      [7:0]  mb_addr_o,
  output logic      [2:0]  mb_baud_o,
  output logic             mb_data7_o,
  output logic      [1:0]  mb_parity_o,
  output logic             mb_stop2_o,
  output logic             mb_crc_lo_first_o,
  output logic             modem_passthrough_mode_o,
  output logic      [2:0]  mb_if_en_o
);

  fmg_regs_type r_reg;
  fmg_regs_type r_next;

  // Memories: command list, output area, input area, slave records
  logic [31:0] list_mem [0:127];
  logic [7:0]  out_mem  [0:255];
  logic [7:0]  in_mem   [0:255];
  logic [7:0]  rec_mem  [0:2047];

  logic        run;
  logic        auto_en;
  logic [31:0] entry;
  logic [6:0]  uidx_nx;
  logic [6:0]  rec_off;
  logic        ap_rd;
  logic [12:0] a;
  logic        w_reg;
  logic        list_we;
  logic        out_we;
  logic        in_we;
  logic        rec_we;
  logic        rcds_we;

  //////////////////////////////////////////////////////////////////////////////
  assign run      = r_reg.ctrl[CTRL_RUN] & r_reg.mode_ok & (r_reg.mode == MODE_NORM | r_reg.mode == MODE_DBG);
  assign auto_en  = r_reg.ctrl[CTRL_AUTO];
  assign entry    = list_mem[r_reg.uidx];
  assign uidx_nx  = (r_reg.uidx + 7'h01 >= r_reg.llen) ? 7'h00 : r_reg.uidx + 7'h01;
  assign rec_off  = fmg_map(r_reg.step, hart_rx_idx_i);
  assign a        = haddr_i[12:0];
  assign ap_rd    = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
  assign w_reg    = r_reg.ap_wr & (r_reg.ap_addr[12:10] == PG_REG);
  assign list_we  = r_reg.ap_wr & (r_reg.ap_addr[12:10] == PG_LIST) & (r_reg.ap_addr[8:2] < LIST_MAX);
  assign out_we   = r_reg.ap_wr & (r_reg.ap_addr[12:10] == PG_OUT);
  assign in_we    = (r_reg.st == ST_WAIT) & hart_rx_valid_i & r_reg.usrc;
  assign rec_we   = (r_reg.st == ST_WAIT) & hart_rx_valid_i & ~r_reg.usrc & (rec_off != REC_STAT);
  assign rcds_we  = (r_reg.st == ST_WAIT) & hart_done_i & hart_ok_i & ~r_reg.usrc;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next       = r_reg;
    r_next.ready = 1'b1;
    // Switch is read once; later changes need a new reset
    if (!r_reg.mode_ok) begin
      r_next.mode    = mode_select_switch_i;
      r_next.mode_ok = 1'b1;
    end

    // Effective serial settings per mode
    r_next.passthru = r_reg.mode_ok & (r_reg.mode == MODE_MODEM);
    r_next.mb_ascii = r_reg.mbcfg[0];
    r_next.mb_data7 = 1'b0;
    r_next.mb_stop2 = 1'b0;
    if (r_reg.mode == MODE_MODEM) begin
      r_next.mb_ascii = 1'b0;
      r_next.mb_addr  = FIX_ADDR;
      r_next.mb_baud  = BAUD_1200;
      r_next.mb_par   = PAR_ODD;
      r_next.mb_crclo = r_reg.mbcfg[16];
    end else if (r_reg.mode == MODE_CFG || r_reg.mode == MODE_DBG) begin
      r_next.mb_ascii = 1'b0;
      r_next.mb_addr  = FIX_ADDR;
      r_next.mb_baud  = BAUD_19200;
      r_next.mb_par   = PAR_EVEN;
      r_next.mb_crclo = 1'b1;
    end else begin
      r_next.mb_addr  = r_reg.mbcfg[8:1];
      r_next.mb_baud  = r_reg.mbcfg[11:9];
      r_next.mb_data7 = r_reg.mbcfg[12];
      r_next.mb_par   = r_reg.mbcfg[14:13];
      r_next.mb_stop2 = r_reg.mbcfg[15];
      r_next.mb_crclo = r_reg.mbcfg[16];
    end
    // One interface enabled; unused code falls back to the first
    case (r_reg.ifsel)
      2'h1:    r_next.if_en = 3'h2;
      2'h2:    r_next.if_en = 3'h4;
      default: r_next.if_en = 3'h1;
    endcase

    // Bus data phase: register writes
    if (w_reg) begin
      if (r_reg.ap_addr == A_CTRL) begin
        r_next.ctrl = hwdata_i[2:0];
      end else if (r_reg.ap_addr == A_SMASK) begin
        r_next.smask = hwdata_i[15:0];
      end else if (r_reg.ap_addr == A_RETRY) begin
        r_next.retry = hwdata_i[3:0];
      end else if (r_reg.ap_addr == A_LLEN) begin
        r_next.llen = (hwdata_i[6:0] > LIST_MAX) ? LIST_MAX : hwdata_i[6:0];
      end else if (r_reg.ap_addr == A_MBCFG) begin
        r_next.mbcfg = hwdata_i[16:0];
      end else if (r_reg.ap_addr == A_IFSEL) begin
        r_next.ifsel = hwdata_i[1:0];
      end
    end
    r_next.ap_wr   = hsel_i & hready_i & htrans_i[1] & hwrite_i;
    r_next.ap_addr = {a[12:2], 2'h0};

    // Bus address phase: read data prepared for the data phase
    r_next.rdata = 32'h0000_0000;
    if (ap_rd) begin
      if (a[12:10] == PG_REG) begin
        if ({a[12:2], 2'h0} == A_CTRL) begin
          r_next.rdata = {29'h0, r_reg.ctrl};
        end else if ({a[12:2], 2'h0} == A_SMASK) begin
          r_next.rdata = {16'h0000, r_reg.smask};
        end else if ({a[12:2], 2'h0} == A_RETRY) begin
          r_next.rdata = {28'h0, r_reg.retry};
        end else if ({a[12:2], 2'h0} == A_LLEN) begin
          r_next.rdata = {25'h0, r_reg.llen};
        end else if ({a[12:2], 2'h0} == A_MBCFG) begin
          r_next.rdata = {15'h0, r_reg.mbcfg};
        end else if ({a[12:2], 2'h0} == A_MBEFF) begin
          r_next.rdata = {11'h000, r_reg.if_en, r_reg.passthru, r_reg.mb_crclo, r_reg.mb_stop2, r_reg.mb_par,
                          r_reg.mb_data7, r_reg.mb_baud, r_reg.mb_addr, r_reg.mb_ascii};
        end else if ({a[12:2], 2'h0} == A_STAT) begin
          r_next.rdata = {r_reg.errcnt, 5'h0, (r_reg.st != ST_IDLE), r_reg.mode, r_reg.online};
        end else if ({a[12:2], 2'h0} == A_IFSEL) begin
          r_next.rdata = {30'h0, r_reg.ifsel};
        end
      end else if (a[12:10] == PG_LIST) begin
        if (a[8:2] < LIST_MAX) begin
          r_next.rdata = list_mem[a[8:2]];
        end
      end else if (a[12:10] == PG_OUT || a[12:10] == PG_IN) begin
        for (int k = 0; k < 4; k++) begin
          r_next.rdata[8*k +: 8] = a[10] ? in_mem[{a[7:2], 2'(k)}] : out_mem[{a[7:2], 2'(k)}];
        end
      end else if (a[12:11] == PG_REC) begin
        for (int k = 0; k < 4; k++) begin
          if ({a[6:2], 2'(k)} == REC_STAT) begin
            r_next.rdata[8*k +: 8] = {3'h0, r_reg.pstat[a[10:7]]};
          end else if ({a[6:2], 2'(k)} <= REC_LAST) begin
            r_next.rdata[8*k +: 8] = rec_mem[{a[10:7], a[6:2], 2'(k)}];
          end
        end
      end
    end

    // Request payload byte, one cycle after its index
    r_next.txb = out_mem[r_reg.outbase + hart_tx_idx_i];

    // Transaction sequencer
    case (r_reg.st)
      ST_IDLE: begin
        if (run) begin
          r_next.uturn = ~r_reg.uturn;
          if (r_reg.uturn) begin
            if (r_reg.llen == 7'h00 || r_reg.uidx >= r_reg.llen) begin
              r_next.uidx = 7'h00;
            end else if (entry[7:0] == 8'h00 || r_reg.online[entry[11:8]]) begin
              r_next.req     = 1'b1;
              r_next.st      = ST_WAIT;
              r_next.usrc    = 1'b1;
              r_next.cmd     = entry[7:0];
              r_next.tslave  = entry[11:8];
              r_next.outbase = entry[23:16];
              r_next.inbase  = entry[31:24];
            end else begin
              r_next.uidx = uidx_nx;
            end
          end else if (r_reg.smask[r_reg.slave] && (!r_reg.online[r_reg.slave] || auto_en)) begin
            r_next.req     = 1'b1;
            r_next.st      = ST_WAIT;
            r_next.usrc    = 1'b0;
            r_next.tslave  = r_reg.slave;
            r_next.outbase = 8'h00;
            if (!r_reg.online[r_reg.slave]) begin
              r_next.step = 3'h0;
              r_next.cmd  = fmg_auto_cmd(3'h0);
            end else begin
              r_next.cmd  = fmg_auto_cmd(r_reg.step);
            end
          end else begin
            r_next.slave = r_reg.slave + 4'h1;
            r_next.step  = 3'h0;
          end
        end
      end
      ST_WAIT: begin
        // Request held until the link answers, so only one is ever open
        if (hart_done_i) begin
          r_next.req = 1'b0;
          r_next.st  = ST_HOLD;
          if (hart_ok_i) begin
            r_next.tries = 4'h0;
            if (r_reg.usrc) begin
              r_next.uidx = uidx_nx;
            end else begin
              r_next.pstat[r_reg.tslave][r_reg.step] = 1'b1;
              if (r_reg.step == 3'h0) begin
                r_next.online[r_reg.tslave] = 1'b1;
              end
              if (auto_en && r_reg.step < STEP_LAST) begin
                r_next.step = r_reg.step + 3'h1;
              end else begin
                r_next.step  = 3'h0;
                r_next.slave = r_reg.slave + 4'h1;
              end
            end
          end else if (r_reg.tries < r_reg.retry) begin
            r_next.tries = r_reg.tries + 4'h1;
            r_next.rpend = 1'b1;
          end else begin
            r_next.tries                = 4'h0;
            r_next.errcnt               = r_reg.errcnt + 8'h01;
            r_next.online[r_reg.tslave] = 1'b0;
            r_next.pstat[r_reg.tslave]  = 5'h00;
            if (r_reg.usrc) begin
              r_next.uidx = uidx_nx;
            end else begin
              r_next.step  = 3'h0;
              r_next.slave = r_reg.slave + 4'h1;
            end
          end
        end
      end
      ST_HOLD: begin
        // One idle cycle so the link sees the request drop
        if (r_reg.rpend) begin
          r_next.rpend = 1'b0;
          r_next.req   = 1'b1;
          r_next.st    = ST_WAIT;
        end else begin
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st  = ST_IDLE;
        r_next.req = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_reg       <= '0;
      r_reg.st    <= ST_IDLE;
      r_reg.ctrl  <= CTRL_RST;
      r_reg.smask <= SMASK_RST;
      r_reg.retry <= RETRY_RST;
      r_reg.mbcfg <= MBCFG_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Memories carry no reset; records keep old data across offline periods
  always_ff @(posedge clk_i) begin
    if (list_we) begin
      list_mem[r_reg.ap_addr[8:2]] <= hwdata_i;
    end
    if (out_we) begin
      for (int k = 0; k < 4; k++) begin
        out_mem[{r_reg.ap_addr[7:2], 2'(k)}] <= hwdata_i[8*k +: 8];
      end
    end
    if (in_we) begin
      in_mem[r_reg.inbase + hart_rx_idx_i] <= hart_rx_byte_i;
    end
    if (rec_we) begin
      rec_mem[{r_reg.tslave, rec_off}] <= hart_rx_byte_i;
    end
    if (rcds_we) begin
      rec_mem[{r_reg.tslave, REC_RC}] <= hart_rc_i;
      rec_mem[{r_reg.tslave, REC_DS}] <= hart_ds_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign hrdata_o                 = r_reg.rdata;
  assign hreadyout_o              = r_reg.ready;
  assign hresp_o                  = 1'b0;
  assign hart_req_o               = r_reg.req;
  assign hart_cmd_o               = r_reg.cmd;
  assign hart_slave_o             = r_reg.tslave;
  assign hart_tx_byte_o           = r_reg.txb;
  assign hart_primary_o           = r_reg.ctrl[CTRL_PRIM];
  assign mb_ascii_o               = r_reg.mb_ascii;
  assign mb_addr_o                = r_reg.mb_addr;
  assign mb_baud_o                = r_reg.mb_baud;
  assign mb_data7_o               = r_reg.mb_data7;
  assign mb_parity_o              = r_reg.mb_par;
  assign mb_stop2_o               = r_reg.mb_stop2;
  assign mb_crc_lo_first_o        = r_reg.mb_crclo;
  assign modem_passthrough_mode_o = r_reg.passthru;
  assign mb_if_en_o               = r_reg.if_en;

endmodule : fmg_gateway

// *** include/fmg_pkg.sv ***
// Constants, types and helper functions of the field-bus polling gateway
package fmg_pkg;

  // Register page (byte addresses, low 13 bits of haddr)
  localparam logic [12:0] A_CTRL   = 13'h0000;
  localparam logic [12:0] A_SMASK  = 13'h0004;
  localparam logic [12:0] A_RETRY  = 13'h0008;
  localparam logic [12:0] A_LLEN   = 13'h000C;
  localparam logic [12:0] A_MBCFG  = 13'h0010;
  localparam logic [12:0] A_MBEFF  = 13'h0014;
  localparam logic [12:0] A_STAT   = 13'h0018;
  localparam logic [12:0] A_IFSEL  = 13'h001C;
  // Pages selected by haddr[12:10]; the record page by haddr[12:11]
  localparam logic [2:0]  PG_REG   = 3'h0;
  localparam logic [2:0]  PG_LIST  = 3'h1;
  localparam logic [2:0]  PG_OUT   = 3'h2;
  localparam logic [2:0]  PG_IN    = 3'h3;
  localparam logic [1:0]  PG_REC   = 2'h2;

  // Control bits and reset values
  localparam int          CTRL_RUN  = 0;
  localparam int          CTRL_AUTO = 1;
  localparam int          CTRL_PRIM = 2;
  localparam logic [2:0]  CTRL_RST  = 3'h7;
  localparam logic [15:0] SMASK_RST = 16'h0000;
  localparam logic [3:0]  RETRY_RST = 4'h3;
  localparam logic [6:0]  LIST_MAX  = 7'h64;
  localparam logic [16:0] MBCFG_RST = 17'h04802;

  // Modbus settings encodings
  localparam logic [1:0]  MODE_NORM  = 2'h0;
  localparam logic [1:0]  MODE_MODEM = 2'h1;
  localparam logic [1:0]  MODE_CFG   = 2'h2;
  localparam logic [1:0]  MODE_DBG   = 2'h3;
  localparam logic [2:0]  BAUD_1200  = 3'h0;
  localparam logic [2:0]  BAUD_19200 = 3'h4;
  localparam logic [1:0]  PAR_ODD    = 2'h1;
  localparam logic [1:0]  PAR_EVEN   = 2'h2;
  localparam logic [7:0]  FIX_ADDR   = 8'h01;

  // Record layout
  localparam logic [6:0]  REC_STAT = 7'h00;
  localparam logic [6:0]  REC_RC   = 7'h01;
  localparam logic [6:0]  REC_DS   = 7'h02;
  localparam logic [6:0]  REC_LAST = 7'h65;
  localparam logic [2:0]  STEP_LAST = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HOLD = 3'b100
  } fmg_state_type;

  typedef struct packed {
    fmg_state_type    st;
    logic [3:0]       slave;
    logic [2:0]       step;
    logic [6:0]       uidx;
    logic             uturn;
    logic             usrc;
    logic             rpend;
    logic [3:0]       tries;
    logic [7:0]       cmd;
    logic [3:0]       tslave;
    logic [7:0]       inbase;
    logic [7:0]       outbase;
    logic [15:0]      online;
    logic [15:0][4:0] pstat;
    logic [7:0]       errcnt;
    logic [1:0]       mode;
    logic             mode_ok;
    logic [2:0]       ctrl;
    logic [15:0]      smask;
    logic [3:0]       retry;
    logic [6:0]       llen;
    logic [16:0]      mbcfg;
    logic [1:0]       ifsel;
    logic             ap_wr;
    logic [12:0]      ap_addr;
    logic [31:0]      rdata;
    logic             ready;
    logic             req;
    logic [7:0]       txb;
    logic             mb_ascii;
    logic [7:0]       mb_addr;
    logic [2:0]       mb_baud;
    logic             mb_data7;
    logic [1:0]       mb_par;
    logic             mb_stop2;
    logic             mb_crclo;
    logic             passthru;
    logic [2:0]       if_en;
  } fmg_regs_type;

  // Built-in poll sequence: 0, 3, 13, 14, 15
  function automatic logic [7:0] fmg_auto_cmd(input logic [2:0] step);
    case (step)
      3'h1:    fmg_auto_cmd = 8'h03;
      3'h2:    fmg_auto_cmd = 8'h0D;
      3'h3:    fmg_auto_cmd = 8'h0E;
      3'h4:    fmg_auto_cmd = 8'h0F;
      default: fmg_auto_cmd = 8'h00;
    endcase
  endfunction : fmg_auto_cmd

  // Response field index to record offset; 0 means not stored
  function automatic logic [6:0] fmg_map(input logic [2:0] step, input logic [7:0] idx);
    logic [6:0] i;
    i = idx[6:0];
    fmg_map = 7'h00;
    if (idx[7] == 1'b0) begin
      case (step)
        3'h0: fmg_map = (i < 7'h11) ? i + 7'h03 : (i == 7'h11) ? 7'h33 : (i < 7'h14) ? i + 7'h2A : 7'h00;
        3'h1: fmg_map = (i < 7'h04) ? i + 7'h14 : (i < 7'h14) ? i + 7'h3A : 7'h00;
        3'h2: fmg_map = (i < 7'h1B) ? i + 7'h18 : 7'h00;
        3'h3: fmg_map = (i < 7'h04) ? i + 7'h34 : (i < 7'h10) ? i + 7'h4A : 7'h00;
        default: fmg_map = (i < 7'h06) ? i + 7'h38 : (i < 7'h12) ? i + 7'h54 : 7'h00;
      endcase
    end
  endfunction : fmg_map

endpackage : fmg_pkg

// *** tb/fmg_gateway_sva.sv ***
// Port assertions for the field-bus polling gateway
`timescale 1ns/1ns
module fmg_gateway_sva
  import fmg_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic [1:0] mode_select_switch_i,
  input wire logic       hart_done_i,
  input wire logic       hart_req_o,
  input wire logic [7:0] hart_cmd_o,
  input wire logic [3:0] hart_slave_o,
  input wire logic       hresp_o,
  input wire logic       hreadyout_o,
  input wire logic [7:0] mb_addr_o,
  input wire logic [2:0] mb_baud_o,
  input wire logic       mb_data7_o,
  input wire logic [1:0] mb_parity_o,
  input wire logic       mb_stop2_o,
  input wire logic       mb_crc_lo_first_o,
  input wire logic       modem_passthrough_mode_o,
  input wire logic [2:0] mb_if_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // Own switch copy, taken at the same first edge
  logic       seen_reg;
  logic [1:0] mode_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else if (!seen_reg) begin
      seen_reg <= 1'b1;
      mode_reg <= mode_select_switch_i;
    end
  end
  ////////////////////////////////////////
  sequence s_busy; hart_req_o && !hart_done_i; endsequence
  sequence s_end; hart_req_o && hart_done_i; endsequence
  property p_req_hold; s_busy |=> hart_req_o && $stable(hart_cmd_o) && $stable(hart_slave_o); endproperty
  property p_req_end; s_end |=> !hart_req_o; endproperty
  property p_okay; hresp_o == 1'b0; endproperty
  property p_ready; seen_reg |-> hreadyout_o; endproperty
  property p_fixed; seen_reg && mode_reg[1] |=> mb_addr_o == FIX_ADDR && mb_baud_o == BAUD_19200
    && mb_parity_o == PAR_EVEN && !mb_data7_o && !mb_stop2_o && mb_crc_lo_first_o; endproperty
  property p_modem; seen_reg && mode_reg == MODE_MODEM |=> mb_addr_o == FIX_ADDR && mb_baud_o == BAUD_1200
    && mb_parity_o == PAR_ODD && !mb_data7_o && !mb_stop2_o; endproperty
  property p_mode; seen_reg |=> modem_passthrough_mode_o == (mode_reg == MODE_MODEM); endproperty
  property p_ifen; seen_reg |=> $onehot(mb_if_en_o); endproperty
  a_req_hold: assert property (p_req_hold) else $error("Request changed before done");
  a_req_end: assert property (p_req_end) else $error("Request not released after done");
  a_okay: assert property (p_okay) else $error("Bus response not OKAY");
  a_ready: assert property (p_ready) else $error("Bus slave not ready");
  a_fixed: assert property (p_fixed) else $error("Fixed serial settings wrong");
  a_modem: assert property (p_modem) else $error("Pass-through serial settings wrong");
  a_mode: assert property (p_mode) else $error("Mode not held from reset");
  a_ifen: assert property (p_ifen) else $error("Serial interface enable not one-hot");
endmodule : fmg_gateway_sva

bind fmg_gateway fmg_gateway_sva u_sva (.clk_i, .rstn_i, .mode_select_switch_i, .hart_done_i, .hart_req_o,
  .hart_cmd_o, .hart_slave_o, .hresp_o, .hreadyout_o, .mb_addr_o, .mb_baud_o, .mb_data7_o, .mb_parity_o,
  .mb_stop2_o, .mb_crc_lo_first_o, .modem_passthrough_mode_o, .mb_if_en_o);

// *** tb/fmg_field_model.sv ***
// Behavioural field slaves answering the gateway's commands
`timescale 1ns/1ns
module fmg_field_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        req_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic [3:0]  slave_i,
  input  wire logic [7:0]  tx_byte_i,
  input  wire logic [15:0] present_i,
  output logic             done_o,
  output logic             ok_o,
  output logic      [7:0]  rc_o,
  output logic      [7:0]  ds_o,
  output logic             rx_valid_o,
  output logic      [7:0]  rx_idx_o,
  output logic      [7:0]  rx_byte_o,
  output logic      [7:0]  tx_idx_o,
  output logic      [31:0] tx_word_o
);
  initial begin
    {done_o, ok_o, rx_valid_o} = 3'h0;
    {rc_o, ds_o, rx_idx_o, rx_byte_o, tx_idx_o} = 40'h0;
    tx_word_o = 32'h0;
    forever begin
      @(posedge clk_i);
      if (rstn_i && req_i) begin
        // Higher addresses answer later
        repeat (slave_i) @(posedge clk_i);
        for (int i = 0; i < 27; i++) begin
          rx_valid_o <= present_i[slave_i];
          rx_idx_o <= i[7:0];
          rx_byte_o <= cmd_i ^ {slave_i, 4'h0} ^ i[7:0];
          tx_idx_o <= i[7:0];
          // Payload byte lags its index by two edges
          if (i >= 2 && i < 6 && cmd_i == 8'h22) tx_word_o[8*(i-2)+:8] <= tx_byte_i;
          @(posedge clk_i);
        end
        rx_valid_o <= 1'b0;
        done_o <= 1'b1;
        ok_o <= present_i[slave_i];
        rc_o <= {slave_i, 4'hA};
        ds_o <= {4'h3, slave_i};
        @(posedge clk_i);
        done_o <= 1'b0;
        ok_o <= ~ok_o;
        rc_o <= ~rc_o;
        ds_o <= ~ds_o;
      end else begin
        // Released receive index and byte lines change every cycle while no request is seen; they hold during the answer delay and the done cycle
        rx_idx_o <= rx_idx_o + 8'h01;
        rx_byte_o <= ~rx_byte_o;
      end
    end
  end
endmodule : fmg_field_model

// *** tb/tb.sv ***
// Self-checking bench for the field-bus polling gateway
`timescale 1ns/1ns
module tb;
  import fmg_pkg::*;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic        hwrite_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [1:0]  mode_select_switch_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [15:0] present = 16'h0002;
  logic [31:0] hrdata_o, rd, v, tx_word;
  logic [7:0]  b, hart_cmd_o, hart_tx_byte_o, mb_addr_o, hart_rc_i, hart_ds_i;
  logic [7:0]  hart_rx_idx_i, hart_rx_byte_i, hart_tx_idx_i;
  logic [3:0]  hart_slave_o;
  logic [2:0]  mb_baud_o, mb_if_en_o;
  logic [1:0]  mb_parity_o;
  logic        hreadyout_o, hresp_o, hart_req_o, hart_primary_o, mb_ascii_o, mb_data7_o, mb_stop2_o;
  logic        mb_crc_lo_first_o, modem_passthrough_mode_o, hart_done_i, hart_ok_i, hart_rx_valid_i;
  int          errors = 0;
  int          compares = 0;
  logic [31:0] rst_v [5] = '{CTRL_RST, SMASK_RST, RETRY_RST, 32'h0, MBCFG_RST};
  // Record offset, command, response index
  logic [23:0] tbl [20] = '{24'h030000, 24'h0E000B, 24'h10000D, 24'h130010, 24'h330011, 24'h140300, 24'h170303,
    24'h3E0304, 24'h4D0313, 24'h180D00, 24'h2F0D17, 24'h320D1A, 24'h340E00, 24'h370E03, 24'h510E07,
    24'h590E0F, 24'h380F00, 24'h3B0F03, 24'h5A0F06, 24'h650F11};
  always #20 clk_i = ~clk_i;
  fmg_gateway DUT (.*, .hsize_i(3'h2), .hready_i(hreadyout_o));
  fmg_field_model u_field (.clk_i, .rstn_i, .req_i(hart_req_o), .cmd_i(hart_cmd_o), .slave_i(hart_slave_o),
    .tx_byte_i(hart_tx_byte_o), .present_i(present), .done_o(hart_done_i), .ok_o(hart_ok_i), .rc_o(hart_rc_i),
    .ds_o(hart_ds_i), .rx_valid_o(hart_rx_valid_i), .rx_idx_o(hart_rx_idx_i), .rx_byte_o(hart_rx_byte_i),
    .tx_idx_o(hart_tx_idx_i), .tx_word_o(tx_word));
  ////////////////////////////////////////
  function automatic logic [7:0] resp(logic [7:0] c, logic [7:0] i);
    return c ^ 8'h10 ^ i;
  endfunction : resp
  task automatic complete_run;
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 50);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 100);
    rd = hrdata_o;
    if (n >= 100) begin
      errors++;
      complete_run();
    end
  endtask : bus
  task automatic rdb(logic [31:0] a);
    bus(1'b0, {a[31:2], 2'h0}, 32'h0);
    b = rd[8*a[1:0]+:8];
  endtask : rdb
  // Polls the register; the gateway works on its own pace
  task automatic waitw(string nm, logic [31:0] a, logic [31:0] m, logic [31:0] e);
    int k;
    k = 0;
    do begin bus(1'b0, a, 32'h0); k++; end while ((rd & m) !== e && k < 800);
    check(nm, rd & m, e);
    if ((rd & m) !== e) complete_run();
  endtask : waitw
  task automatic do_reset(logic [1:0] m);
    rstn_i <= 1'b0;
    mode_select_switch_i <= m;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : do_reset
  ////////////////////////////////////////
  initial begin
    void'($urandom(69289));
    for (int m = 3; m >= 0; m--) begin
      do_reset(m[1:0]);
      mode_select_switch_i <= ~m[1:0];
      repeat (3) @(posedge clk_i);
      check("passthru", modem_passthrough_mode_o, m == 1);
      check("baud", mb_baud_o, m == 1 ? BAUD_1200 : BAUD_19200);
      check("parity", mb_parity_o, m == 1 ? PAR_ODD : PAR_EVEN);
      check("crc", mb_crc_lo_first_o, m > 1);
      check("addr", mb_addr_o, FIX_ADDR);
    end
    for (int j = 0; j < 5; j++) begin
      bus(1'b0, 32'h4 * j, 32'h0);
      check("reset", rd, rst_v[j]);
    end
    bus(1'b0, 32'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    v = $urandom & 32'h1BFFF;
    bus(1'b1, 32'h10, v);
    bus(1'b0, 32'h10, 32'h0);
    check("mbcfg", rd, v);
    check("mbout", {mb_crc_lo_first_o, mb_stop2_o, mb_parity_o, mb_data7_o, mb_baud_o, mb_addr_o, mb_ascii_o},
      v[16:0]);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 32'h1C, s);
      repeat (2) @(posedge clk_i);
      check("ifen", mb_if_en_o, s == 3 ? 3'h1 : 3'h1 << s);
    end
    // Sequencer stopped while the list is built, else stale entries run
    bus(1'b1, 32'h0, 32'h0);
    v = $urandom;
    bus(1'b1, 32'h800, v);
    bus(1'b1, 32'h400, 32'h1000_0122);
    bus(1'b1, 32'hC, 32'h7F);
    bus(1'b0, 32'hC, 32'h0);
    check("llen", rd, 32'h64);
    bus(1'b1, 32'hC, 32'h1);
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b1, 32'h4, 32'h6);
    check("second", hart_primary_o, 1'b0);
    bus(1'b1, 32'h0, 32'h7);
    waitw("poll", 32'h1080, 32'h7F, 32'h1F);
    check("first", hart_primary_o, 1'b1);
    waitw("online", 32'h18, 32'h0100_0006, 32'h0100_0002);
    check("errcnt", rd[31:24], 8'h01);
    for (int j = 0; j < 20; j++) begin
      rdb(32'h1080 + tbl[j][23:16]);
      check("record", b, resp(tbl[j][15:8], tbl[j][7:0]));
    end
    rdb(32'h1081);
    check("rc", b, 8'h1A);
    rdb(32'h1082);
    check("ds", b, 8'h31);
    rdb(32'h10E6);
    check("beyond", b, 8'h0);
    waitw("input", 32'hC10, 32'hFFFFFFFF, {resp(8'h22, 3), resp(8'h22, 2), resp(8'h22, 1), resp(8'h22, 0)});
    check("payload", tx_word, v);
    bus(1'b1, 32'hC10, 32'h0);
    waitw("in_ro", 32'hC10, 32'hFFFFFFFF, {resp(8'h22, 3), resp(8'h22, 2), resp(8'h22, 1), resp(8'h22, 0)});
    present <= 16'h0;
    waitw("offline", 32'h18, 32'h2, 32'h0);
    rdb(32'h1080);
    check("pstat", b, 8'h0);
    rdb(32'h108E);
    check("kept", b, resp(8'h0, 8'h0B));
    present <= 16'h0002;
    waitw("reprobe", 32'h18, 32'h2, 32'h2);
    complete_run();
  end
endmodule : tb
